// ---- dv/fmpc_flash_model.sv ----
`timescale 1ns/1ps
module fmpc_flash_model
  import fmpc_pkg::*;
#(
  parameter bit         BOTTOM   = 1'b0,  // boot layout
  parameter logic [7:0] MFR_CODE = 8'h3c, // arbitrary value
  parameter logic [7:0] DEV_CODE = 8'hc5  // arbitrary value
) (
  input wire fmpc_pins_s    pins,     // strobes from host
  input wire logic [DW-1:0] dq_bus,   // resolved data wires
  input wire logic [6:0]    prot_set, // protection bits, zero as delivered
  input wire logic          supply_low, // supply under lockout level
  output logic [DW-1:0]     fl_dq,    // flash drive values
  output logic [DW-1:0]     fl_oe     // flash drive enables
);
  logic [15:0] mem [int];
  logic [16:0] wa;
  logic [15:0] w;
  logic [1:0]  step = 2'h0;
  logic        ident = 1'b0;
  logic        prog = 1'b0;
  realtime     t_fall = 0;
  function automatic int sec_of(input logic [4:0] a);
    if (BOTTOM) begin
      if (a[4:3] != 2'h0) return 3 + a[4:3];
      if (a[2]) return 3;
      return a[1] ? 1 + a[0] : 0;
    end
    if (a[4:3] != 2'h3) return a[4:3];
    if (!a[2]) return 3;
    return a[1] ? 6 : 4 + a[0];
  endfunction
  always @(negedge pins.we_n) begin
    wa = pins.addr;
    t_fall = $realtime;
  end
  always @(negedge pins.rst_n) begin
    step = 2'h0;
    ident = 1'b0;
    prog = 1'b0;
  end
  // short pulses are noise; only a clean ce/we low, oe high cycle counts
  always @(posedge pins.we_n) begin
    if (supply_low) begin
      step = 2'h0;
      ident = 1'b0;
      prog = 1'b0;
    end else if (pins.rst_n && !pins.ce_n && pins.oe_n && $realtime - t_fall >= GLITCH_NS) begin
      if (prog) begin
        if (!prot_set[sec_of(wa[16:12])] || pins.rst_elevated) mem[int'(wa)] = dq_bus;
        prog = 1'b0;
      end else if (dq_bus[7:0] == 8'hf0) begin
        ident = 1'b0;
        step = 2'h0;
      end else if (step == 2'h0 && wa[10:0] == 11'h555 && dq_bus[7:0] == 8'haa) step = 2'h1;
      else if (step == 2'h1 && wa[10:0] == 11'h2aa && dq_bus[7:0] == 8'h55) step = 2'h2;
      else begin
        if (step == 2'h2 && wa[10:0] == 11'h555 && dq_bus[7:0] == 8'h90) ident = 1'b1;
        else if (step == 2'h2 && wa[10:0] == 11'h555 && dq_bus[7:0] == 8'ha0) prog = 1'b1;
        step = 2'h0;
      end
    end
  end
  always @* begin
    w = mem.exists(int'(pins.addr)) ? mem[int'(pins.addr)] : 16'hffff;
    if (pins.a9_elevated || ident) begin
      case (pins.addr[1:0])
        2'h0: fl_dq = {8'h0, MFR_CODE};
        2'h1: fl_dq = {8'h0, DEV_CODE};
        default: fl_dq = {15'h0, prot_set[sec_of(pins.addr[16:12])]};
      endcase
    end else fl_dq = pins.byte_n ? w : {8'h0, dq_bus[15] ? w[15:8] : w[7:0]};
    fl_oe = '0;
    if (!pins.ce_n && !pins.oe_n && pins.rst_n) fl_oe = (pins.byte_n && !ident) ? 16'hffff : 16'h00ff;
  end
endmodule

// ---- dv/fmpc_host_ctrl_monitor.sv ----
`timescale 1ns/1ps
module fmpc_host_ctrl_monitor
  import fmpc_pkg::*;
#(
  parameter logic [7:0]  RST_CMD = RST_CMD_DFLT, // reset command data byte
  parameter int unsigned RST_CYC = RST_LOW_CYC   // reset pin low time
) (
  input wire logic          core_clk,   // clock
  input wire logic          rst,        // sync reset
  input wire logic          req_valid,  // request strobe
  input wire fmpc_req_s     req,        // request fields
  input wire logic          byte_mode,  // bus width select
  input wire logic          tmp_unprot, // temporary unprotect
  input wire logic          req_ready,  // idle
  input wire logic          resp_valid, // completion pulse
  input wire logic [DW-1:0] resp_data,  // read data
  input wire logic          must_reset, // reset command owed
  input wire fmpc_pins_s    pins,       // flash strobes
  input wire logic [DW-1:0] dq_o,       // data drive
  input wire logic [DW-1:0] dq_oe,      // data enables
  input wire logic [DW-1:0] dq_i        // data levels
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [CNT_W-1:0] low_cnt_ff;
  // counts flash reset low time, cleared whenever the pin is high
  always_ff @(posedge core_clk) begin
    if (rst || pins.rst_n) low_cnt_ff <= '0;
    else low_cnt_ff <= low_cnt_ff + 1'b1;
  end
  chk_write_strobes: assert property (!pins.we_n |-> !pins.ce_n && pins.oe_n)
    else $error("write strobe without chip enable or with output enable");
  chk_no_bus_fight: assert property (!pins.oe_n |-> dq_oe[14:0] == '0)
    else $error("host drives data while flash outputs");
  chk_we_pulse_len: assert property ($fell(pins.we_n) |-> !pins.we_n [*6] ##1 pins.we_n)
    else $error("write pulse length wrong");
  chk_data_hold: assert property ($rose(pins.we_n) |-> !pins.ce_n && $stable(dq_o))
    else $error("data or chip enable not held at write end");
  chk_ident_pins: assert property (pins.a9_elevated |-> !pins.addr[6] && pins.addr[1:0] != 2'h3)
    else $error("identifier select pins wrong");
  chk_unprot_follow: assert property (!$past(rst) |-> pins.rst_elevated == $past(tmp_unprot))
    else $error("unprotect detect does not follow request");
  chk_byte_pin: assert property (!$past(rst) |-> pins.byte_n == !$past(byte_mode))
    else $error("width select pin wrong");
  chk_reset_width: assert property ($rose(pins.rst_n) |-> low_cnt_ff == CNT_W'(RST_CYC))
    else $error("flash reset pulse width wrong");
  chk_ident_flagged: assert property (req_valid && req_ready && req.op == OP_WRITE && req.enters_ident
    |-> ##[2:80] must_reset)
    else $error("identifier entry not flagged");
  chk_reset_clears: assert property (req_valid && req_ready && req.op == OP_RESET_CMD
    |-> ##[2:80] !must_reset)
    else $error("reset command left flag set");
  chk_resp_bound: assert property (req_valid && req_ready |-> ##[2:300] resp_valid)
    else $error("request never completed");
  cov_write: cover property ($rose(pins.we_n));
  cov_hv: cover property (pins.a9_elevated && resp_valid);
  cov_hw_reset: cover property ($rose(pins.rst_n));
endmodule

bind fmpc_host_ctrl fmpc_host_ctrl_monitor #(.RST_CMD(RST_CMD), .RST_CYC(RST_CYC)) mon (
  .core_clk   (core_clk),
  .rst        (rst),
  .req_valid  (req_valid),
  .req        (req),
  .byte_mode  (byte_mode),
  .tmp_unprot (tmp_unprot),
  .req_ready  (req_ready),
  .resp_valid (resp_valid),
  .resp_data  (resp_data),
  .must_reset (must_reset),
  .pins       (pins),
  .dq_o       (dq_o),
  .dq_oe      (dq_oe),
  .dq_i       (dq_i)
);

// ---- dv/fmpc_host_ctrl_tb.sv ----
`timescale 1ns/1ps
module fmpc_host_ctrl_tb
  import fmpc_pkg::*;
;
  localparam logic [7:0] MFR = 8'h3c; // arbitrary value
  localparam logic [7:0] DEV = 8'hc5; // arbitrary value
  localparam logic [6:0][16:0] SEC_BASE = {17'h1e000, 17'h1d000, 17'h1c000, 17'h18000, 17'h10000, 17'h08000, 17'h0};
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  fmpc_req_s req = '0;
  logic byte_mode = 1'b0;
  logic tmp_unprot = 1'b0;
  logic [6:0] prot_set = 7'h0;
  logic supply_low = 1'b0;
  logic req_ready, resp_valid, must_reset;
  logic [DW-1:0] resp_data, dq_o, dq_oe, fl_dq, fl_oe, dq_bus;
  logic [DW-1:0] float_pat = 16'h5a5a;
  fmpc_pins_s pins;
  int num_errors = 0;
  int checks_done = 0;
  logic [15:0] q;
  always #2.5 core_clk = ~core_clk;
  // released wires wander so a stale value never passes for data
  always @(posedge core_clk) float_pat <= ~float_pat;
  assign dq_bus = (dq_oe & dq_o) | (~dq_oe & fl_oe & fl_dq) | (~dq_oe & ~fl_oe & float_pat);
  fmpc_host_ctrl #(.RST_CYC(4)) DUT (.core_clk(core_clk), .rst(rst), .req_valid(req_valid), .req(req),
    .byte_mode(byte_mode), .tmp_unprot(tmp_unprot), .req_ready(req_ready), .resp_valid(resp_valid),
    .resp_data(resp_data), .must_reset(must_reset), .pins(pins), .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_bus));
  fmpc_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) flash (.pins(pins), .dq_bus(dq_bus),
    .prot_set(prot_set), .supply_low(supply_low), .fl_dq(fl_dq), .fl_oe(fl_oe));
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("ERROR %s expected %h got %h", what, exp, got);
      num_errors++;
    end
  endtask
  task automatic do_req(input fmpc_op_e op, input logic [17:0] a, input logic [15:0] d, input logic ent);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 500) begin
      @(posedge core_clk);
      #1 n++;
    end
    @(posedge core_clk);
    req_valid <= 1'b1;
    req <= '{op: op, addr: a, wdata: d, ident_sel: d[0], enters_ident: ent};
    @(posedge core_clk);
    req_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge core_clk);
      #1 n++;
    end while (resp_valid !== 1'b1 && n < 500);
    chk("completion", 16'h1, {15'h0, resp_valid});
    q = resp_data;
  endtask
  task automatic unlock(input logic [7:0] cmd, input logic ent);
    do_req(OP_WRITE, 18'h555, 16'haa, 1'b0);
    do_req(OP_WRITE, 18'h2aa, 16'h55, 1'b0);
    do_req(OP_WRITE, 18'h555, {8'h0, cmd}, ent);
  endtask
  task automatic t_prog(input logic [16:0] a, input logic [15:0] d, input logic [15:0] exp);
    unlock(8'ha0, 1'b0);
    do_req(OP_WRITE, {1'b0, a}, d, 1'b0);
    do_req(OP_READ, {1'b0, a}, 16'h0, 1'b0);
    chk("array word", exp, q);
  endtask
  task automatic t_prot_map();
    for (int i = 0; i < 7; i++) begin
      do_req(OP_PROT_HV, {1'b0, SEC_BASE[i]}, 16'h0, 1'b0);
      chk("protect status", {15'h0, prot_set[i]}, q);
    end
  endtask
  // writes under lockout must leave the array untouched
  task automatic t_lockout();
    @(posedge core_clk);
    supply_low <= 1'b1;
    t_prog(17'h08010, 16'h0042, 16'hffff);
    @(posedge core_clk);
    supply_low <= 1'b0;
  endtask
  task automatic t_ident();
    unlock(8'h90, 1'b1);
    chk("flag after ident", 16'h1, {15'h0, must_reset});
  endtask
  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    #1 chk("flash reset idle", 16'h1, {15'h0, pins.rst_n});
    do_req(OP_ID_HV, 18'h0, 16'h0, 1'b0);
    chk("maker code", {8'h0, MFR}, q);
    do_req(OP_ID_HV, 18'h0, 16'h1, 1'b0);
    chk("device code", {8'h0, DEV}, q);
    t_prot_map();
    @(posedge core_clk);
    prot_set <= 7'h51;
    t_prot_map();
    // data bit 5 kept low so an array read does not raise the timeout flag
    t_prog(17'h08004, 16'h1214, 16'h1214);
    t_prog(17'h00004, 16'h0f0f, 16'hffff);
    @(posedge core_clk);
    tmp_unprot <= 1'b1;
    t_prog(17'h00006, 16'h00aa, 16'h00aa);
    @(posedge core_clk);
    tmp_unprot <= 1'b0;
    t_prog(17'h1e008, 16'h0001, 16'hffff);
    do_req(OP_WRITE, 18'h555, 16'haa, 1'b0);
    do_req(OP_WRITE, 18'h555, 16'ha0, 1'b0);
    do_req(OP_WRITE, 18'h0a000, 16'h0, 1'b0);
    do_req(OP_READ, 18'h0a000, 16'h0, 1'b0);
    chk("out of order", 16'hffff, q);
    t_lockout();
    t_ident();
    do_req(OP_READ, 18'h08004, 16'h0, 1'b0);
    chk("array after ident", 16'h1214, q);
    chk("flag cleared", 16'h0, {15'h0, must_reset});
    t_ident();
    do_req(OP_RESET_CMD, 18'h0, {8'h0, RST_CMD_DFLT}, 1'b0);
    chk("flag reset cmd", 16'h0, {15'h0, must_reset});
    t_ident();
    do_req(OP_HW_RESET, 18'h0, 16'h0, 1'b0);
    chk("flag hw reset", 16'h0, {15'h0, must_reset});
    @(posedge core_clk);
    byte_mode <= 1'b1;
    repeat (4) @(posedge core_clk);
    do_req(OP_READ, {17'h08004, 1'b1}, 16'h0, 1'b0);
    chk("high byte", 16'h0012, q);
    do_req(OP_READ, {17'h08004, 1'b0}, 16'h0, 1'b0);
    chk("low byte", 16'h0014, q);
    report_and_stop();
  end
  initial begin
    #400000;
    num_errors++;
    report_and_stop();
  end
endmodule

// ---- src/fmpc_host_ctrl.sv ----
`timescale 1ns/1ps
// How it works
// - elevated A9, A6 low, A1:A0 choose maker, device or protection code
// - host puts sector on upper address bits; reads one if protected
// - write only while chip and write enable low and output enable high
// - after timeout flag or identifier mode, reset command before array reads
module fmpc_host_ctrl
  import fmpc_pkg::*;
#(
  parameter logic [7:0]  RST_CMD = RST_CMD_DFLT,   // reset command data byte
  parameter int unsigned RST_CYC = RST_LOW_CYC     // reset pin low time in cycles
) (
  input  wire logic          core_clk,      // 200 MHz clock
  input  wire logic          rst,           // sync reset, active high
  input  wire logic          req_valid,     // request strobe
  input  wire fmpc_req_s     req,           // request fields
  input  wire logic          byte_mode,     // 1: 8-bit bus, 0: 16-bit bus
  input  wire logic          tmp_unprot,    // hold flash in temporary unprotect
  output logic               req_ready,     // idle, request may be given
  output logic               resp_valid,    // one-cycle completion pulse
  output logic [DW-1:0]      resp_data,     // read data
  output logic               must_reset,    // array reads need reset command first
  output fmpc_pins_s         pins,          // flash strobes and address
  output logic [DW-1:0]      dq_o,          // data pin drive values
  output logic [DW-1:0]      dq_oe,         // data pin drive enables
  input  wire logic [DW-1:0] dq_i           // data pin levels
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WSETUP,
    ST_WPULSE,
    ST_WHOLD,
    ST_RWAIT,
    ST_HWRST,
    ST_DONE
  } fmpc_state_e;

  fmpc_state_e      state_ff;
  logic [CNT_W-1:0] cnt_ff;
  fmpc_req_s        cur_ff;
  logic             pend_read_ff;
  fmpc_pins_s       pins_ff;
  logic [DW-1:0]    dq_o_ff;
  logic [DW-1:0]    dq_oe_ff;
  logic             ready_ff;
  logic             resp_valid_ff;
  logic [DW-1:0]    resp_data_ff;
  logic             must_reset_ff;
  logic [DW-1:0]    dq_sync;

  fmpc_pin_sync #(.WIDTH(DW)) u_dq_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .pin_i    (dq_i),
    .level_o  (dq_sync)
  );

  // byte mode: bit 0 of the byte address goes out on pin fifteen as A-1
  function automatic logic [AW-1:0] pin_addr(input logic [AW:0] a, input logic bm);
    pin_addr = bm ? a[AW:1] : a[AW-1:0];
  endfunction

  // elevated-voltage identifier address: A9 level carried separately, A6 low
  function automatic logic [AW-1:0] hv_addr(input logic [SEC_W-1:0] sec, input logic [1:0] sel);
    logic [AW-1:0] a;
    a = '0;
    a[SEC_LSB +: SEC_W] = sec;
    a[1:0] = sel;
    hv_addr = a;
  endfunction

  function automatic logic is_hv(input fmpc_op_e op);
    is_hv = (op == OP_ID_HV) || (op == OP_PROT_HV);
  endfunction

  // sequencing and timing
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_ff     <= ST_IDLE;
      cnt_ff       <= '0;
      cur_ff       <= '0;
      pend_read_ff <= 1'b0;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          if (req_valid) begin
            cur_ff <= req;
            pend_read_ff <= 1'b0;
            cnt_ff <= CNT_W'(SETUP_CYC);
            unique case (req.op)
              OP_READ: begin
                if (must_reset_ff) begin
                  // reset command slipped in ahead of the array read
                  cur_ff.op <= OP_RESET_CMD;
                  pend_read_ff <= 1'b1;
                  state_ff <= ST_WSETUP;
                end else begin
                  cnt_ff <= CNT_W'(ACC_CYC + SYNC_CYC);
                  state_ff <= ST_RWAIT;
                end
              end
              OP_ID_HV, OP_PROT_HV: begin
                cnt_ff <= CNT_W'(ACC_CYC + SYNC_CYC);
                state_ff <= ST_RWAIT;
              end
              OP_WRITE, OP_RESET_CMD: state_ff <= ST_WSETUP;
              OP_HW_RESET: begin
                cnt_ff <= CNT_W'(RST_CYC);
                state_ff <= ST_HWRST;
              end
              default: state_ff <= ST_DONE;
            endcase
          end
        end
        ST_WSETUP: begin
          if (cnt_ff <= CNT_W'(1)) begin
            cnt_ff <= CNT_W'(WE_LOW_CYC);
            state_ff <= ST_WPULSE;
          end else begin
            cnt_ff <= cnt_ff - CNT_W'(1);
          end
        end
        ST_WPULSE: begin
          if (cnt_ff <= CNT_W'(1)) begin
            cnt_ff <= CNT_W'(HOLD_CYC);
            state_ff <= ST_WHOLD;
          end else begin
            cnt_ff <= cnt_ff - CNT_W'(1);
          end
        end
        ST_WHOLD: begin
          if (cnt_ff <= CNT_W'(1)) begin
            if (pend_read_ff) begin
              pend_read_ff <= 1'b0;
              cur_ff.op <= OP_READ;
              cnt_ff <= CNT_W'(ACC_CYC + SYNC_CYC);
              state_ff <= ST_RWAIT;
            end else begin
              state_ff <= ST_DONE;
            end
          end else begin
            cnt_ff <= cnt_ff - CNT_W'(1);
          end
        end
        ST_RWAIT, ST_HWRST: begin
          if (cnt_ff <= CNT_W'(1)) begin
            state_ff <= ST_DONE;
          end else begin
            cnt_ff <= cnt_ff - CNT_W'(1);
          end
        end
        ST_DONE: state_ff <= ST_IDLE;
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // flash strobes, address and elevated-voltage controls
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pins_ff <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, rst_n: 1'b1, byte_n: 1'b1,
                   a9_elevated: 1'b0, rst_elevated: 1'b0, addr: '0};
    end else begin
      pins_ff.byte_n <= ~byte_mode;
      pins_ff.rst_elevated <= tmp_unprot;
      pins_ff.rst_n <= (state_ff != ST_HWRST);
      pins_ff.ce_n <= 1'b1;
      pins_ff.oe_n <= 1'b1;
      pins_ff.we_n <= 1'b1;
      pins_ff.a9_elevated <= 1'b0;
      unique case (state_ff)
        ST_WSETUP: begin
          // output enable stays high for the whole write window
          pins_ff.ce_n <= 1'b0;
          pins_ff.addr <= pin_addr(cur_ff.addr, byte_mode);
        end
        ST_WPULSE: begin
          // write enable falls last, so it latches the address
          pins_ff.ce_n <= 1'b0;
          pins_ff.we_n <= 1'b0;
        end
        ST_WHOLD: begin
          // write enable rises first, so it latches the data
          pins_ff.ce_n <= 1'b0;
        end
        ST_RWAIT: begin
          pins_ff.ce_n <= 1'b0;
          pins_ff.oe_n <= 1'b0;
          if (is_hv(cur_ff.op)) begin
            pins_ff.a9_elevated <= 1'b1;
            pins_ff.addr <= hv_addr(cur_ff.addr[SEC_LSB +: SEC_W],
                                    (cur_ff.op == OP_PROT_HV) ? SEL_PROT :
                                    (cur_ff.ident_sel ? SEL_DEV : SEL_MFR));
          end else begin
            pins_ff.addr <= pin_addr(cur_ff.addr, byte_mode);
          end
        end
        default: begin
        end
      endcase
    end
  end

  // data pin drive: write data only inside a write; in byte mode pin fifteen also drives A-1 through every read and write
  always_ff @(posedge core_clk) begin
    if (rst) begin
      dq_o_ff  <= '0;
      dq_oe_ff <= '0;
    end else begin
      dq_o_ff  <= '0;
      dq_oe_ff <= '0;
      if (state_ff == ST_WSETUP || state_ff == ST_WPULSE || state_ff == ST_WHOLD) begin
        dq_o_ff  <= (cur_ff.op == OP_RESET_CMD) ? DW'(RST_CMD) : cur_ff.wdata;
        dq_oe_ff <= byte_mode ? DW'({LOW_BYTE_W{1'b1}}) : '1;
      end
      if (byte_mode && state_ff != ST_IDLE && state_ff != ST_DONE && state_ff != ST_HWRST) begin
        dq_o_ff[BYTE_LSB_PIN]  <= cur_ff.addr[0];
        dq_oe_ff[BYTE_LSB_PIN] <= 1'b1;
      end
    end
  end

  // completion and read capture
  always_ff @(posedge core_clk) begin
    if (rst) begin
      resp_valid_ff <= 1'b0;
      resp_data_ff  <= '0;
    end else begin
      resp_valid_ff <= (state_ff == ST_DONE);
      if (state_ff == ST_RWAIT && cnt_ff <= CNT_W'(1)) begin
        if (byte_mode || is_hv(cur_ff.op)) begin
          resp_data_ff <= {{(DW - LOW_BYTE_W){1'b0}}, dq_sync[LOW_BYTE_W-1:0]};
        end else begin
          resp_data_ff <= dq_sync;
        end
      end
    end
  end

  // tracks when the flash will not give array data until reset command
  always_ff @(posedge core_clk) begin
    if (rst) begin
      must_reset_ff <= 1'b0;
    end else if (state_ff == ST_RWAIT && cnt_ff <= CNT_W'(1) && cur_ff.op == OP_READ
                 && dq_sync[TIMEOUT_BIT]) begin
      must_reset_ff <= 1'b1;
    end else if (state_ff == ST_WHOLD && cnt_ff <= CNT_W'(1) && cur_ff.op == OP_WRITE
                 && cur_ff.enters_ident) begin
      must_reset_ff <= 1'b1;
    end else if ((state_ff == ST_WHOLD && cnt_ff <= CNT_W'(1) && cur_ff.op == OP_RESET_CMD)
                 || state_ff == ST_HWRST) begin
      must_reset_ff <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ready_ff <= 1'b0;
    end else begin
      ready_ff <= (state_ff == ST_DONE) || (state_ff == ST_IDLE && !req_valid);
    end
  end

  assign req_ready  = ready_ff;
  assign resp_valid = resp_valid_ff;
  assign resp_data  = resp_data_ff;
  assign must_reset = must_reset_ff;
  assign pins       = pins_ff;
  assign dq_o       = dq_o_ff;
  assign dq_oe      = dq_oe_ff;

endmodule

// ---- src/fmpc_pin_sync.sv ----
`timescale 1ns/1ps
module fmpc_pin_sync #(
  parameter int unsigned WIDTH = 16
) (
  input  wire logic             core_clk, // system clock
  input  wire logic             rst,      // sync reset, active high
  input  wire logic [WIDTH-1:0] pin_i,    // asynchronous pin levels
  output logic      [WIDTH-1:0] level_o   // filtered level
);

  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;
  logic [WIDTH-1:0] level_ff;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
    end else begin
      s1_ff <= pin_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // a bit moves only once two settled stages agree
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_ff @(posedge core_clk) begin
        if (rst) begin
          level_ff[g] <= 1'b0;
        end else if (s2_ff[g] == s3_ff[g]) begin
          level_ff[g] <= s3_ff[g];
        end
      end
    end
  endgenerate

  assign level_o = level_ff;

endmodule

// ---- src/fmpc_pkg.sv ----
package fmpc_pkg;

  localparam int unsigned CLK_NS        = 5;
  // figure below which a strobe pulse may be taken for noise by the flash
  localparam int unsigned GLITCH_NS     = 5;
  localparam int unsigned GLITCH_CYC    = (GLITCH_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned SETUP_NS      = 10;
  localparam int unsigned SETUP_CYC     = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  // write pulse held well clear of the noise figure
  localparam int unsigned WE_LOW_NS     = 30;
  localparam int unsigned WE_LOW_CYC    = (WE_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned HOLD_NS       = 10;
  localparam int unsigned HOLD_CYC      = (HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned ACC_NS        = 100;
  localparam int unsigned ACC_CYC       = (ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned SYNC_CYC      = 4;
  localparam int unsigned RST_LOW_NS    = 500;
  localparam int unsigned RST_LOW_CYC   = (RST_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CNT_W         = 8;

  localparam int unsigned AW            = 17;
  localparam int unsigned DW            = 16;
  localparam int unsigned SEC_W         = 5;
  localparam int unsigned SEC_LSB       = 12;
  localparam int unsigned TIMEOUT_BIT   = 5;
  localparam int unsigned BYTE_LSB_PIN  = 15;
  localparam int unsigned LOW_BYTE_W    = 8;

  // identifier selects on A1:A0 with A6 held low
  localparam logic [1:0]  SEL_MFR       = 2'h0;
  localparam logic [1:0]  SEL_DEV       = 2'h1;
  localparam logic [1:0]  SEL_PROT      = 2'h2;
  localparam logic [7:0]  RST_CMD_DFLT  = 8'hf0;

  typedef enum logic [2:0] {
    OP_READ,
    OP_WRITE,
    OP_ID_HV,
    OP_PROT_HV,
    OP_RESET_CMD,
    OP_HW_RESET
  } fmpc_op_e;

  typedef struct packed {
    fmpc_op_e          op;
    logic [AW:0]       addr;
    logic [DW-1:0]     wdata;
    logic              ident_sel;
    logic              enters_ident;
  } fmpc_req_s;

  typedef struct packed {
    logic              ce_n;
    logic              oe_n;
    logic              we_n;
    logic              rst_n;
    logic              byte_n;
    logic              a9_elevated;
    logic              rst_elevated;
    logic [AW-1:0]     addr;
  } fmpc_pins_s;

endpackage
